// *** spread_clock_pkg.sv ***
package spread_clock_pkg;

  // serial address: write byte D4h, read byte D5h
  localparam logic [6:0] SLAVE_ADDR = 7'h6A;

  // register indexes
  localparam logic [6:0] IDX_SPREAD_FREQ = 7'h00;
  localparam logic [6:0] IDX_OUT_PUMP    = 7'h01;
  localparam logic [6:0] IDX_ID          = 7'h06;
  // byte count reported at the head of a block read
  localparam logic [7:0] BLOCK_COUNT     = 8'h07;

  // command code
  localparam int CMD_BYTE_MODE_BIT = 7;

  // spread_and_frequency_control fields
  localparam int B0_SPREAD_HI = 7;
  localparam int B0_SPREAD_LO = 4;
  localparam int B0_PIN_HI    = 6;
  localparam int B0_FREQ      = 3;
  localparam int B0_SPREAD_EN = 1;
  localparam int B0_OWNER     = 0;
  localparam logic [7:0] SPREAD_FREQ_RST   = 8'h02;
  localparam logic [7:0] SPREAD_FREQ_WMASK = 8'hFB;

  // output_and_pump_control fields
  localparam int B1_DIFF_ON = 2;
  localparam int B1_PUMP_HI = 1;
  localparam int B1_PUMP_LO = 0;
  localparam logic [7:0] OUT_PUMP_RST   = 8'h04;
  localparam logic [7:0] OUT_PUMP_WMASK = 8'h07;

  // charge-pump encodings
  localparam logic [1:0] PUMP_DEFAULT = 2'h0;
  localparam logic [1:0] PUMP_UP_ONE  = 2'h3;
  localparam logic [1:0] PUMP_UP_TWO  = 2'h2;

  // identification byte: values are arbitrary
  localparam logic [3:0] REVISION_CODE = 4'h3;
  localparam logic [3:0] VENDOR_CODE   = 4'h5;

  // cycles after reset release before straps are taken (covers synchroniser)
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  typedef struct packed {
    logic [3:0] spreadSelect;
    logic       outputFreqChoice;
    logic       spreadOn;
    logic       diffOutputOn;
    logic [1:0] pumpLevel;
  } clock_ctrl_t;

endpackage

// *** sync_stage.sv ***
`timescale 1ns/1ps
module sync_stage #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] firstStage;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      firstStage <= '0;
      dout       <= '0;
    end else begin
      firstStage <= din;
      dout       <= firstStage;
    end
  end

endmodule

// *** spread_clock_control_regs.sv ***
// What this block does
// (RL1) Every register takes its default at power-up; no programming needed.
// (RL2) Strap pin sampled at power-up (1=100 MHz); then drives reference out.
// (RL3) Byte 0 bit 3 selects output frequency; resets to strapped value.
// (RL4) Byte 0 bit 0: 0 pins govern, 1 register governs; resets 0.
// (RL5) Byte 0 bits 7:4 spread select; bit 7 resets 0, others from pins.
// (RL6) Byte 0 bit 1 enables spread modulation; resets to 1.
// (RL7) Host writes zero to reserved bits; they reset to zero.
// (RL8) Byte 1 bit 2 enables the differential output pair; resets to 1.
// (RL9) Byte 1 bits 1:0 charge pump: 00 default, 11 up one, 10 up two.
// (RL10) Bytes 2 to 5 have no function; host must not rely on them.
// (RL11) Byte 6 is read-only: revision code high, vendor code low.
// (RL12) Power-down is entered while the sleep input is high.
// (RL13) Command bit 7: 0 block access from byte 0, 1 single indexed byte.
// (RL14) Device answers at address byte D4h for writes, D5h for reads.
// (RL15) Writes to the identification byte are acknowledged but ignored.
`timescale 1ns/1ps
module spread_clock_control_regs (
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  input  wire logic                          scl,
  input  wire logic                          sdaIn,
  output logic                               sdaOut,
  output logic                               sdaOe,
  input  wire logic                          referenceInputClock,
  input  wire logic                          sleepRequest,
  input  wire logic                          spreadSelB1,
  input  wire logic                          spreadSelB2,
  input  wire logic                          spreadSelB3,
  input  wire logic                          freqStrapRefOutputIn,
  output logic                               freqStrapRefOutputOut,
  output logic                               freqStrapRefOutputOe,
  output spread_clock_pkg::clock_ctrl_t      clockCtrl,
  output logic                               sleepActive
);

  typedef enum {
    IDLE, ADDR, CMD, COUNT, WDATA, TCOUNT, TDATA
  } smb_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [7:0] rawIn;
  logic [7:0] syncIn;
  logic       sclS;
  logic       sdaS;
  logic       refS;
  logic       sleepS;
  logic       strapS;
  logic [2:0] pinSpread;

  assign rawIn = {~scl, ~sdaIn, referenceInputClock, sleepRequest,
                  freqStrapRefOutputIn, spreadSelB1, spreadSelB2, spreadSelB3};

  sync_stage #(.WIDTH(8)) inSync (
    .mclk (mclk),
    .rstn (rstn),
    .din  (rawIn),
    .dout (syncIn)
  );

  // bus lines pass inverted so the synchroniser's reset reads as idle high
  assign {sclS, sdaS} = ~syncIn[7:6];
  assign {refS, sleepS, strapS} = syncIn[5:3];
  assign pinSpread = syncIn[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // bus line edges, start and stop

  logic sclD;
  logic sdaD;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end else begin
      sclD <= sclS;
      sdaD <= sdaS;
    end
  end

  assign sclRise   = sclS & ~sclD;
  assign sclFall   = ~sclS & sclD;
  assign startSeen = sclS & sclD & sdaD & ~sdaS;
  assign stopSeen  = sclS & sclD & ~sdaD & sdaS;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release

  logic [2:0] settleCnt;
  logic       strapDone;
  logic       strapTake;
  logic       strapFreq;

  assign strapTake = !strapDone &&
                     (settleCnt == spread_clock_pkg::STRAP_SETTLE - 3'h1);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      settleCnt <= 3'h0;
      strapDone <= 1'b0;
      strapFreq <= 1'b0;
    end else if (!strapDone) begin
      settleCnt <= settleCnt + 3'h1;
      if (strapTake) begin
        strapDone <= 1'b1;
        strapFreq <= strapS; // RL2
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] spreadFreqCtl;
  logic [7:0] outPumpCtl;
  logic       wrStrobe;
  logic [6:0] wrIndex;
  logic [7:0] wrData;
  logic [6:0] index;
  logic [7:0] readByte;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      spreadFreqCtl <= spread_clock_pkg::SPREAD_FREQ_RST; // RL1 RL4 RL6
    end else if (strapTake) begin
      spreadFreqCtl[spread_clock_pkg::B0_PIN_HI:spread_clock_pkg::B0_SPREAD_LO]
        <= pinSpread; // RL5
      spreadFreqCtl[spread_clock_pkg::B0_FREQ] <= strapS; // RL3
    end else if (wrStrobe && wrIndex == spread_clock_pkg::IDX_SPREAD_FREQ) begin
      spreadFreqCtl <= wrData & spread_clock_pkg::SPREAD_FREQ_WMASK; // RL7
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      outPumpCtl <= spread_clock_pkg::OUT_PUMP_RST; // RL8 RL9
    end else if (wrStrobe && wrIndex == spread_clock_pkg::IDX_OUT_PUMP) begin
      outPumpCtl <= wrData & spread_clock_pkg::OUT_PUMP_WMASK; // RL7
    end
  end

  // bytes 2..5 read zero; the id byte has no write path
  always_comb begin
    unique case (index)
      spread_clock_pkg::IDX_SPREAD_FREQ: readByte = spreadFreqCtl;
      spread_clock_pkg::IDX_OUT_PUMP:    readByte = outPumpCtl;
      spread_clock_pkg::IDX_ID:          readByte =
        {spread_clock_pkg::REVISION_CODE, spread_clock_pkg::VENDOR_CODE}; // RL11
      default:                           readByte = 8'h00; // RL10
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial engine

  smb_state_t state;
  logic [7:0] shiftReg;
  logic [3:0] bitCnt;
  logic       rxAck;
  logic       hostAckPhase;
  logic       hostAck;
  logic       blockMode;

  assign sdaOut = 1'b0;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state        <= IDLE;
      shiftReg     <= 8'h00;
      bitCnt       <= 4'h0;
      rxAck        <= 1'b0;
      hostAckPhase <= 1'b0;
      hostAck      <= 1'b0;
      blockMode    <= 1'b0;
      index        <= 7'h00;
      sdaOe        <= 1'b0;
      wrStrobe     <= 1'b0;
      wrIndex      <= 7'h00;
      wrData       <= 8'h00;
    end else begin
      wrStrobe <= 1'b0;
      if (startSeen) begin
        state        <= ADDR;
        bitCnt       <= 4'h0;
        rxAck        <= 1'b0;
        hostAckPhase <= 1'b0;
        sdaOe        <= 1'b0;
      end else if (stopSeen) begin
        state        <= IDLE;
        rxAck        <= 1'b0;
        hostAckPhase <= 1'b0;
        sdaOe        <= 1'b0;
      end else if (rxAck) begin
        if (sclFall) begin
          rxAck  <= 1'b0;
          bitCnt <= 4'h0;
          sdaOe  <= 1'b0;
          if (state == TCOUNT) begin
            shiftReg <= spread_clock_pkg::BLOCK_COUNT;
            sdaOe    <= ~spread_clock_pkg::BLOCK_COUNT[7];
          end else if (state == TDATA) begin
            shiftReg <= readByte;
            sdaOe    <= ~readByte[7];
            index    <= index + 7'h1;
          end
        end
      end else if (state == TCOUNT || state == TDATA) begin
        if (sclRise && hostAckPhase) begin
          hostAck <= ~sdaS;
        end
        if (sclFall) begin
          if (!hostAckPhase) begin
            if (bitCnt == 4'h7) begin
              sdaOe        <= 1'b0;
              hostAckPhase <= 1'b1;
            end else begin
              shiftReg <= {shiftReg[6:0], 1'b0};
              sdaOe    <= ~shiftReg[6];
              bitCnt   <= bitCnt + 4'h1;
            end
          end else begin
            hostAckPhase <= 1'b0;
            bitCnt       <= 4'h0;
            if (hostAck) begin
              state    <= TDATA;
              shiftReg <= readByte;
              sdaOe    <= ~readByte[7];
              index    <= index + 7'h1;
            end else begin
              state <= IDLE;
            end
          end
        end
      end else if (state != IDLE) begin
        if (sclRise && bitCnt != 4'h8) begin
          shiftReg <= {shiftReg[6:0], sdaS};
          bitCnt   <= bitCnt + 4'h1;
        end
        if (sclFall && bitCnt == 4'h8) begin
          rxAck <= 1'b1;
          sdaOe <= 1'b1;
          unique case (state)
            ADDR: begin
              if (shiftReg[7:1] != spread_clock_pkg::SLAVE_ADDR) begin // RL14
                state <= IDLE;
                rxAck <= 1'b0;
                sdaOe <= 1'b0;
              end else if (shiftReg[0]) begin
                state <= blockMode ? TCOUNT : TDATA;
              end else begin
                state <= CMD;
              end
            end
            CMD: begin
              blockMode <= ~shiftReg[spread_clock_pkg::CMD_BYTE_MODE_BIT];
              if (shiftReg[spread_clock_pkg::CMD_BYTE_MODE_BIT]) begin // RL13
                index <= shiftReg[6:0];
                state <= WDATA;
              end else begin
                index <= 7'h00;
                state <= COUNT;
              end
            end
            COUNT: state <= WDATA;
            default: begin
              wrStrobe <= 1'b1; // RL15
              wrIndex  <= index;
              wrData   <= shiftReg;
              index    <= index + 7'h1;
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective controls and pin outputs

  logic owner;

  assign owner = spreadFreqCtl[spread_clock_pkg::B0_OWNER];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clockCtrl <= '0;
    end else begin
      clockCtrl.spreadSelect <= owner ?
        spreadFreqCtl[spread_clock_pkg::B0_SPREAD_HI:
                      spread_clock_pkg::B0_SPREAD_LO] :
        {1'b0, pinSpread}; // RL4 RL5
      clockCtrl.outputFreqChoice <= owner ?
        spreadFreqCtl[spread_clock_pkg::B0_FREQ] : strapFreq; // RL3 RL4
      clockCtrl.spreadOn <= spreadFreqCtl[spread_clock_pkg::B0_SPREAD_EN]; // RL6
      clockCtrl.diffOutputOn <=
        outPumpCtl[spread_clock_pkg::B1_DIFF_ON] & ~sleepS; // RL8 RL12
      clockCtrl.pumpLevel <=
        outPumpCtl[spread_clock_pkg::B1_PUMP_HI:spread_clock_pkg::B1_PUMP_LO]; // RL9
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sleepActive           <= 1'b0;
      freqStrapRefOutputOe  <= 1'b0;
      freqStrapRefOutputOut <= 1'b0;
    end else begin
      sleepActive           <= sleepS; // RL12
      freqStrapRefOutputOe  <= strapDone; // RL2
      freqStrapRefOutputOut <= strapDone & ~sleepS & refS; // RL2
    end
  end

endmodule

// *** spread_clock_control_regs_checker.sv ***
`timescale 1ns/1ps
module spread_clock_control_regs_checker (
  input wire logic                          mclk,
  input wire logic                          rstn,
  input wire logic                          scl,
  input wire logic                          sdaOe,
  input wire logic                          sleepRequest,
  input wire logic                          spreadSelB1,
  input wire logic                          spreadSelB2,
  input wire logic                          spreadSelB3,
  input wire logic                          freqStrapRefOutputIn,
  input wire logic                          freqStrapRefOutputOut,
  input wire logic                          freqStrapRefOutputOe,
  input wire logic                          sleepActive,
  input wire spread_clock_pkg::clock_ctrl_t clockCtrl
);
  logic [2:0] upCnt;

  // edges since reset release, saturating
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      upCnt <= 3'h0;
    else if (upCnt != 3'h7)
      upCnt <= upCnt + 3'h1;
  end

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_drive_not_early:
    assert property (upCnt < 3'h5 |-> !freqStrapRefOutputOe)
    else $error("strap pin driven too early");
  a_drive_after_strap:
    assert property (upCnt >= 3'h5 |-> freqStrapRefOutputOe)
    else $error("strap pin not driven after strap");
  a_ref_quiet_undriven:
    assert property (!freqStrapRefOutputOe |-> !freqStrapRefOutputOut)
    else $error("reference output active while undriven");
  a_freq_strap_taken:
    assert property (upCnt == 3'h5 |->
      clockCtrl.outputFreqChoice == $past(freqStrapRefOutputIn, 2))
    else $error("frequency does not follow strap");
  a_spread_pins_taken:
    assert property (upCnt == 3'h5 |-> clockCtrl.spreadSelect ==
      {1'b0, spreadSelB1, spreadSelB2, spreadSelB3})
    else $error("spread select does not follow pins");
  a_reset_defaults:
    assert property (upCnt == 3'h2 && !sleepActive |-> clockCtrl.spreadOn
      && clockCtrl.diffOutputOn && clockCtrl.pumpLevel == 2'h0)
    else $error("control defaults wrong after reset");
  a_sleep_follows:
    assert property ($rose(sleepRequest) |-> ##[1:4] sleepActive)
    else $error("sleep not entered");
  a_sleep_gates_out:
    assert property (sleepActive && $past(sleepActive) |->
      !clockCtrl.diffOutputOn && !freqStrapRefOutputOut)
    else $error("outputs active during sleep");
  a_sda_moves_low:
    assert property ($changed(sdaOe) |-> !scl)
    else $error("data line changed while clock high");
endmodule

bind spread_clock_control_regs spread_clock_control_regs_checker chk (
  .mclk(mclk), .rstn(rstn), .scl(scl), .sdaOe(sdaOe),
  .sleepRequest(sleepRequest), .spreadSelB1(spreadSelB1),
  .spreadSelB2(spreadSelB2), .spreadSelB3(spreadSelB3),
  .freqStrapRefOutputIn(freqStrapRefOutputIn),
  .freqStrapRefOutputOut(freqStrapRefOutputOut),
  .freqStrapRefOutputOe(freqStrapRefOutputOe),
  .sleepActive(sleepActive), .clockCtrl(clockCtrl)
);

// *** smbus_host_model.sv ***
`timescale 1ns/1ps
module smbus_host_model (
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // clock low 240 ns, high 80 ns; stands high between frames
  task automatic bitOut(input logic b);
    #120 sdaLow = !b;
    #120 scl = 1'b1;
    #80 scl = 1'b0;
  endtask

  task automatic bitIn(output logic b);
    #40 sdaLow = 1'b0;
    #200 scl = 1'b1;
    #40 b = sdaWire;
    #40 scl = 1'b0;
  endtask

  // waits out a device acknowledge before raising the clock
  task automatic start();
    #40 sdaLow = 1'b0;
    #200 scl = 1'b1;
    #120 sdaLow = 1'b1;
    #160 scl = 1'b0;
  endtask

  task automatic stop();
    #200 sdaLow = 1'b1;
    #120 scl = 1'b1;
    #120 sdaLow = 1'b0;
    #240;
  endtask

  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      bitOut(d[i]);
    bitIn(b);
    ack = !b;
  endtask

  task automatic recvByte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--)
      bitIn(d[i]);
    bitOut(last);
  endtask
endmodule

// *** tb_spread_clock_control_regs.sv ***
`timescale 1ns/1ps
module tb_spread_clock_control_regs;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wr;
    logic [7:0] rdExp;
    logic [8:0] ccExp;
  } row_t;
  logic                          mclk;
  logic                          rstn;
  logic                          refClk;
  logic                          sleepRequest;
  logic                          strap;
  logic                          scl;
  logic                          hostLow;
  logic                          sdaOut;
  logic                          sdaOe;
  logic                          refOut;
  logic                          refOe;
  logic                          sleepActive;
  logic                          ack;
  logic [7:0]                    rd;
  int                            n_errors = 0;
  int                            samples_checked = 0;
  int                            cycles = 0;
  wire                           sdaWire =
    !hostLow && (sdaOe !== 1'b1 || sdaOut === 1'b1);
  wire                           strapPin = refOe ? refOut : strap;
  spread_clock_pkg::clock_ctrl_t clockCtrl;
  row_t rows [8] = '{
    '{8'h01, 8'h06, 8'h06, 9'h0AE}, '{8'h01, 8'h03, 8'h03, 9'h0AB},
    '{8'h01, 8'h00, 8'h00, 9'h0A8}, '{8'h00, 8'hA9, 8'hA9, 9'h150},
    '{8'h00, 8'h5B, 8'h5B, 9'h0B8}, '{8'h06, 8'hFF, 8'h35, 9'h0B8},
    '{8'h02, 8'h77, 8'h00, 9'h0B8}, '{8'h00, 8'h00, 8'h00, 9'h0A0}};

  spread_clock_control_regs dut (
    .mclk(mclk), .rstn(rstn), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .referenceInputClock(refClk),
    .sleepRequest(sleepRequest), .spreadSelB1(1'b1), .spreadSelB2(1'b0),
    .spreadSelB3(1'b1), .freqStrapRefOutputIn(strapPin),
    .freqStrapRefOutputOut(refOut), .freqStrapRefOutputOe(refOe),
    .clockCtrl(clockCtrl), .sleepActive(sleepActive));
  smbus_host_model host (.sdaWire(sdaWire), .scl(scl), .sdaLow(hostLow));

  //////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    refClk = 1'b0;
    forever #35 refClk = ~refClk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic resetDut(input logic s, input logic [8:0] cc);
    @(negedge mclk);
    rstn = 1'b0;
    strap = s;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    repeat (8) @(negedge mclk);
    check(clockCtrl, cc);
    check(9'(refOe), 9'h001);
    $display("reset test done");
  endtask

  task automatic wrByte(input logic [7:0] idx, input logic [7:0] d);
    @(negedge mclk);
    host.start();
    host.sendByte(8'hD4, ack);
    check(9'(ack), 9'h001);
    host.sendByte(8'h80 | idx, ack);
    check(9'(ack), 9'h001);
    host.sendByte(d, ack);
    check(9'(ack), 9'h001);
    host.stop();
  endtask

  task automatic rdByte(input logic [7:0] idx);
    @(negedge mclk);
    host.start();
    host.sendByte(8'hD4, ack);
    host.sendByte(8'h80 | idx, ack);
    host.start();
    host.sendByte(8'hD5, ack);
    check(9'(ack), 9'h001);
    host.recvByte(rd, 1'b1);
    host.stop();
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    sleepRequest = 1'b0;
    resetDut(1'b0, 9'h0AC);
    rdByte(8'h00);
    check(9'(rd), 9'h052);
    foreach (rows[i]) begin
      wrByte(rows[i].idx, rows[i].wr);
      repeat (4) @(negedge mclk);
      check(clockCtrl, rows[i].ccExp);
      rdByte(rows[i].idx);
      check(9'(rd), 9'(rows[i].rdExp));
      $display("row %0d done", i);
    end
    host.start();
    host.sendByte(8'hD4, ack);
    host.sendByte(8'h00, ack);
    host.start();
    host.sendByte(8'hD5, ack);
    host.recvByte(rd, 1'b0);
    check(9'(rd), 9'h007);
    host.recvByte(rd, 1'b1);
    check(9'(rd), 9'h000);
    host.stop();
    host.start();
    host.sendByte(8'hD0, ack);
    check(9'(ack), 9'h000);
    host.stop();
    $display("block read and address test done");
    wrByte(8'h01, 8'h04);
    @(negedge mclk);
    sleepRequest = 1'b1;
    repeat (8) @(negedge mclk);
    check(9'(sleepActive), 9'h001);
    check(9'(clockCtrl.diffOutputOn), 9'h000);
    sleepRequest = 1'b0;
    repeat (8) @(negedge mclk);
    check(9'(clockCtrl.diffOutputOn), 9'h001);
    $display("sleep test done");
    resetDut(1'b1, 9'h0BC);
    finish_test();
  end
endmodule
